//--- common/serial_rx_pkg.sv
// Purpose: Constants for the serial receive control and baud generator
// Assumes: 125 MHz clk stands in for the oscillator, one cycle per tick
// Notes on behaviour
// - Port enable plus both direction bits hand the two pins to the port
// - Nine-bit select chooses 9-bit reception when one, 8-bit when zero
// - Single receive only in sync master; cleared when reception ends
// - One 8-bit baud generator serves async and sync operation
// - Divisor register sets the period of a free running 8-bit timer
// - In async mode the high-speed select changes the baud divide
// - In sync mode the high-speed select is ignored
// - Sync baud equations apply only as master; slave clock comes from outside
// - High-speed divides by sixteen times divisor plus one
// - Writing the divisor resets the generator timer at once
// - Receive pin sampled three times, level by majority vote
// - Async rate is clk/(64(X+1)) low speed, clk/(16(X+1)) high
// - Sync master clock is clk/(4(X+1)), divisor 0 to 255
package serial_rx_pkg;
    localparam logic [7:0] RCV_CTRL_OFS = 8'h18;
    localparam logic [7:0] XMT_CTRL_OFS = 8'h98;
    localparam logic [7:0] DIVISOR_OFS = 8'h99;
    localparam logic [7:0] PORTB_DIR_OFS = 8'h86;
    localparam logic [7:0] RX_DATA_OFS = 8'h1a;
    localparam int PORT_EN_BIT = 7;
    localparam int NINE_SEL_BIT = 6;
    localparam int SINGLE_RX_BIT = 5;
    localparam int CONT_RX_BIT = 4;
    localparam int ADDR_DET_BIT = 3;
    localparam int FRAME_ERR_BIT = 2;
    localparam int OVERRUN_BIT = 1;
    localparam int NINTH_BIT_POS = 0;
    localparam int CSRC_BIT = 7;
    localparam int SYNC_BIT = 4;
    localparam int HIGH_SPEED_BIT = 2;
    localparam int RXPIN_DIR_BIT = 1;
    localparam int CKPIN_DIR_BIT = 2;
    localparam logic [7:0] RCV_CTRL_RST = 8'h00;
    localparam logic [7:0] XMT_CTRL_RST = 8'h02;
    localparam logic [7:0] DIVISOR_RST = 8'h00;
    localparam logic [7:0] PORTB_DIR_RST = 8'hff;
    // Prescale beyond the 8-bit timer: ticks per baud period unit
    // Async ticks are 1/16 bit, so the /16 of the bit is not prescaled here
    localparam logic [5:0] PRE_LOW = 6'h03;
    localparam logic [5:0] PRE_HIGH = 6'h00;
    localparam logic [5:0] PRE_SYNC = 6'h01;
    // Async frame sampled at three points around the middle of 16 ticks
    localparam logic [3:0] OVS_LAST = 4'hf;
    localparam logic [3:0] OVS_MID = 4'h8;
endpackage

//--- src/majority_sampler.sv
// Purpose: Three-sample majority detector for the receive pin
// Assumes: pin already synchronous to clk
// Notes: three samples are taken on consecutive sample strobes
`timescale 1ns/100ps
module majority_sampler (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pin,
    input wire logic sample,
    output logic level
);
    logic [2:0] hist_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hist_r <= 3'h7;
        end else if (sample) begin
            hist_r <= {hist_r[1:0], pin};
        end
    end

    // Two of three wins
    assign level = (hist_r[0] & hist_r[1]) | (hist_r[0] & hist_r[2]) |
                   (hist_r[1] & hist_r[2]);
endmodule

//--- src/serial_rx_control.sv
// Purpose: Receive control, status flags and shared baud generator
// Assumes: single clk domain; pins synchronous; reg port per house bus
// Notes: sync mode receives 8 or 9 bits, LSB first, on rising clock edge
`timescale 1ns/100ps
module serial_rx_control (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic rx_pin_in,
    output logic rx_pin_out,
    output logic rx_pin_oe,
    input wire logic ck_pin_in,
    output logic ck_pin_out,
    output logic ck_pin_oe,
    output logic port_owned,
    output logic rx_irq
);
    typedef enum logic [1:0] {IDLE, START, DATA, STOP} rx_state_t;

    logic [7:0] rcv_ctrl_r, xmt_ctrl_r, divisor_r, dir_r, buf_r;
    logic frame_err_buf_r, frame_err_r, overrun_r, ninth_buf_r, ninth_r, full_r;
    logic [7:0] tmr_r;
    logic [5:0] pre_r;
    logic tick_r, ck_r, ck_prev_r;
    logic [3:0] ovs_r, bit_cnt_r;
    logic [8:0] shift_r;
    rx_state_t state_r;
    logic level, owned, sync_m, master, nine, done, accept;
    logic [5:0] pre_top;
    logic [3:0] last_bit;
    logic ck_edge, samp_strobe;

    assign sync_m = xmt_ctrl_r[serial_rx_pkg::SYNC_BIT];
    assign master = xmt_ctrl_r[serial_rx_pkg::CSRC_BIT];
    assign nine = rcv_ctrl_r[serial_rx_pkg::NINE_SEL_BIT];
    assign last_bit = nine ? 4'h8 : 4'h7;
    assign owned = rcv_ctrl_r[serial_rx_pkg::PORT_EN_BIT] &
        dir_r[serial_rx_pkg::RXPIN_DIR_BIT] &
        dir_r[serial_rx_pkg::CKPIN_DIR_BIT];

    // Prescale: sync /4, async /16 high or /64 low
    always_comb begin
        if (sync_m) begin
            pre_top = serial_rx_pkg::PRE_SYNC;
        end else if (xmt_ctrl_r[serial_rx_pkg::HIGH_SPEED_BIT]) begin
            pre_top = serial_rx_pkg::PRE_HIGH;
        end else begin
            pre_top = serial_rx_pkg::PRE_LOW;
        end
    end

    // One 8-bit generator; divisor write restarts it mid-count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tmr_r <= 8'h00;
            pre_r <= 6'h00;
            tick_r <= 1'b0;
        end else if (wr && addr == serial_rx_pkg::DIVISOR_OFS) begin
            tmr_r <= 8'h00;
            pre_r <= 6'h00;
            tick_r <= 1'b0;
        end else if (tmr_r == divisor_r) begin
            tmr_r <= 8'h00;
            tick_r <= 1'b0;
            if (pre_r >= pre_top) begin
                pre_r <= 6'h00;
                tick_r <= 1'b1;
            end else begin
                pre_r <= pre_r + 6'h01;
            end
        end else begin
            tmr_r <= tmr_r + 8'h01;
            tick_r <= 1'b0;
        end
    end

    // Async tick is 1/16 bit; sync tick is one master clock half-period
    // scaled so a full clock period equals clk/(4(X+1))
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ck_r <= 1'b1;
            ck_prev_r <= 1'b1;
        end else begin
            ck_prev_r <= master ? ck_r : ck_pin_in;
            if (!(sync_m && master && state_r == DATA)) begin
                ck_r <= 1'b1;
            end else if (tick_r) begin
                ck_r <= ~ck_r;
            end
        end
    end

    logic ck_now;
    assign ck_now = master ? ck_r : ck_pin_in;
    assign ck_edge = ck_now & ~ck_prev_r;
    assign samp_strobe = sync_m ? ck_edge : tick_r;

    majority_sampler u_maj (
        .clk(clk),
        .rst_n(rst_n),
        .pin(rx_pin_in),
        .sample(samp_strobe),
        .level(level)
    );

    logic rx_en;
    // Continuous wins over single; single counts only in sync master
    assign rx_en = owned & (rcv_ctrl_r[serial_rx_pkg::CONT_RX_BIT] |
        (sync_m & master &
        rcv_ctrl_r[serial_rx_pkg::SINGLE_RX_BIT]));
    assign done = (state_r == STOP && !sync_m && tick_r &&
        ovs_r == serial_rx_pkg::OVS_MID) ||
        (state_r == DATA && sync_m && ck_edge && bit_cnt_r == last_bit);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= IDLE;
            ovs_r <= 4'h0;
            bit_cnt_r <= 4'h0;
            shift_r <= 9'h000;
        end else if (!rx_en) begin
            state_r <= IDLE;
        end else begin
            case (state_r)
                IDLE: begin
                    bit_cnt_r <= 4'h0;
                    ovs_r <= 4'h0;
                    if (sync_m) begin
                        state_r <= DATA;
                    end else if (tick_r && !level) begin
                        state_r <= START;
                    end
                end
                START: begin
                    if (tick_r) begin
                        ovs_r <= ovs_r + 4'h1;
                        if (ovs_r == serial_rx_pkg::OVS_MID && level) begin
                            state_r <= IDLE;
                        end else if (ovs_r == serial_rx_pkg::OVS_LAST) begin
                            state_r <= DATA;
                        end
                    end
                end
                DATA: begin
                    if (sync_m) begin
                        if (ck_edge) begin
                            shift_r <= {level, shift_r[8:1]};
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                            if (bit_cnt_r == last_bit) begin
                                state_r <= IDLE;
                            end
                        end
                    end else if (tick_r) begin
                        ovs_r <= ovs_r + 4'h1;
                        if (ovs_r == serial_rx_pkg::OVS_MID) begin
                            shift_r <= {level, shift_r[8:1]};
                        end
                        if (ovs_r == serial_rx_pkg::OVS_LAST) begin
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                            if (bit_cnt_r == last_bit) begin
                                state_r <= STOP;
                            end
                        end
                    end
                end
                STOP: begin
                    if (tick_r) begin
                        ovs_r <= ovs_r + 4'h1;
                        if (ovs_r == serial_rx_pkg::OVS_MID) begin
                            state_r <= IDLE;
                        end
                    end
                end
                default: state_r <= IDLE;
            endcase
        end
    end

    logic [8:0] frame;
    assign frame = nine ? shift_r : {1'b0, shift_r[8:1]};
    // Address frames only, when async 9-bit detect is on
    assign accept = done & ~(~sync_m & nine &
        rcv_ctrl_r[serial_rx_pkg::ADDR_DET_BIT] & ~frame[8]);

    logic buf_read;
    assign buf_read = rd && addr == serial_rx_pkg::RX_DATA_OFS;

    // Buffer with status pinned to the byte it arrived with
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            buf_r <= 8'h00;
            full_r <= 1'b0;
            ninth_buf_r <= 1'b0;
            frame_err_buf_r <= 1'b0;
            overrun_r <= 1'b0;
            rx_irq <= 1'b0;
        end else begin
            if (accept && full_r) begin
                overrun_r <= 1'b1;
            end else if (!rcv_ctrl_r[serial_rx_pkg::CONT_RX_BIT]) begin
                overrun_r <= 1'b0;
            end
            if (accept && !full_r && !overrun_r) begin
                buf_r <= frame[7:0];
                ninth_buf_r <= frame[8];
                frame_err_buf_r <= ~sync_m & ~level;
                full_r <= 1'b1;
            end else if (buf_read) begin
                full_r <= 1'b0;
            end
            rx_irq <= full_r;
        end
    end

    // Framing error and ninth bit in the control register refresh on buffer read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_err_r <= 1'b0;
            ninth_r <= 1'b0;
        end else if (buf_read) begin
            frame_err_r <= frame_err_buf_r;
            ninth_r <= ninth_buf_r;
        end
    end

    // Software registers; single receive self-clears on completion
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rcv_ctrl_r <= serial_rx_pkg::RCV_CTRL_RST;
            xmt_ctrl_r <= serial_rx_pkg::XMT_CTRL_RST;
            divisor_r <= serial_rx_pkg::DIVISOR_RST;
            dir_r <= serial_rx_pkg::PORTB_DIR_RST;
        end else begin
            if (wr && addr == serial_rx_pkg::RCV_CTRL_OFS) begin
                rcv_ctrl_r <= {wdata[7:3], 3'h0};
            end
            if (done && sync_m && master &&
                !rcv_ctrl_r[serial_rx_pkg::CONT_RX_BIT]) begin
                rcv_ctrl_r[serial_rx_pkg::SINGLE_RX_BIT] <= 1'b0;
            end
            if (wr && addr == serial_rx_pkg::XMT_CTRL_OFS) begin
                xmt_ctrl_r <= {wdata[7:4], 1'b0, wdata[2], 1'b1, wdata[0]};
            end
            if (wr && addr == serial_rx_pkg::DIVISOR_OFS) begin
                divisor_r <= wdata;
            end
            if (wr && addr == serial_rx_pkg::PORTB_DIR_OFS) begin
                dir_r <= wdata;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (rd) begin
            case (addr)
                serial_rx_pkg::RCV_CTRL_OFS:
                    rdata <= {rcv_ctrl_r[7:3], frame_err_r, overrun_r, ninth_r};
                serial_rx_pkg::XMT_CTRL_OFS: rdata <= xmt_ctrl_r;
                serial_rx_pkg::DIVISOR_OFS: rdata <= divisor_r;
                serial_rx_pkg::PORTB_DIR_OFS: rdata <= dir_r;
                serial_rx_pkg::RX_DATA_OFS: rdata <= buf_r;
                default: rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    // Pin ownership; the clock pin is driven only as sync master
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port_owned <= 1'b0;
            ck_pin_out <= 1'b1;
            ck_pin_oe <= 1'b0;
            rx_pin_out <= 1'b1;
            rx_pin_oe <= 1'b0;
        end else begin
            port_owned <= owned;
            ck_pin_out <= ck_r;
            ck_pin_oe <= owned & sync_m & master;
            rx_pin_out <= 1'b1;
            rx_pin_oe <= 1'b0;
        end
    end

    a_single_clear: assert property (@(posedge clk) disable iff (!rst_n)
        done && sync_m && master && !rcv_ctrl_r[serial_rx_pkg::CONT_RX_BIT] &&
        !wr |=> !rcv_ctrl_r[serial_rx_pkg::SINGLE_RX_BIT])
        else $error("single receive not cleared");
    a_divisor_restart: assert property (@(posedge clk) disable iff (!rst_n)
        wr && addr == serial_rx_pkg::DIVISOR_OFS |=> tmr_r == 8'h00)
        else $error("timer not reset on divisor write");
    a_timer_bound: assert property (@(posedge clk) disable iff (!rst_n)
        $past(tmr_r) == divisor_r && !$past(wr) |-> tmr_r == 8'h00)
        else $error("timer overran divisor");
    a_owned_pins: assert property (@(posedge clk) disable iff (!rst_n)
        ck_pin_oe |-> port_owned)
        else $error("clock pin driven while not owned");
    a_overrun_clear: assert property (@(posedge clk) disable iff (!rst_n)
        !rcv_ctrl_r[serial_rx_pkg::CONT_RX_BIT] && !accept |=> !overrun_r)
        else $error("overrun not cleared");
    a_addr_filter: assert property (@(posedge clk) disable iff (!rst_n)
        done && !sync_m && nine && rcv_ctrl_r[serial_rx_pkg::ADDR_DET_BIT] &&
        !frame[8] && !full_r && !buf_read |=> !full_r)
        else $error("data frame accepted in address mode");
    a_nine_len: assert property (@(posedge clk) disable iff (!rst_n)
        state_r == DATA |-> bit_cnt_r <= last_bit)
        else $error("bit count beyond frame");
    a_slave_clock: assert property (@(posedge clk) disable iff (!rst_n)
        sync_m && !master |-> !ck_pin_oe)
        else $error("slave drives clock");
endmodule

//--- bench/remote_tx.sv
// Purpose: Far-side serial peer driving the receive data line
// Assumes: frames are clocked from clk; idle level of the line is high
// Notes: one bit lasts bitc cycles; gl drops a one-cycle glitch mid bit 3
`timescale 1ns/100ps
module remote_tx (
    input wire logic clk,
    output logic line
);
    initial line = 1'b1;

    task automatic send(input logic [7:0] d, input logic nine,
        input logic b8, input logic stop_ok, input int bitc, input bit gl);
        logic [10:0] f;
        // Eight-bit frames end in an idle bit, nine-bit ones in the stop bit
        f = nine ? {stop_ok, b8, d, 1'b0} : {1'b1, stop_ok, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            for (int c = 0; c < bitc; c++) begin
                @(posedge clk);
                line <= f[i] ^ (gl && i == 3 && c == bitc / 2);
            end
        end
        @(posedge clk);
        line <= 1'b1;
        repeat (2 * bitc) @(posedge clk);
    endtask
endmodule

//--- bench/serial_rx_control_tb_top.sv
// Purpose: Self-checking bench for the receive control and baud generator
// Assumes: reads are checked through a queue of expected values
// Notes: bit periods follow the documented divide, not the tick counter
`timescale 1ns/100ps
module serial_rx_control_tb_top;
    localparam logic [7:0] A_CTL = serial_rx_pkg::RCV_CTRL_OFS;
    localparam logic [7:0] A_TX = serial_rx_pkg::XMT_CTRL_OFS;
    localparam logic [7:0] A_DIV = serial_rx_pkg::DIVISOR_OFS;
    localparam logic [7:0] A_DIR = serial_rx_pkg::PORTB_DIR_OFS;
    localparam logic [7:0] A_BUF = serial_rx_pkg::RX_DATA_OFS;
    logic clk, rst_n, wr, rd, rx_line, ck_pin_in, rd_seen, hs;
    logic [7:0] addr, wdata, rdata, d, ctl, dir, x;
    logic rx_pin_out, rx_pin_oe, ck_pin_out, ck_pin_oe, port_owned, rx_irq;
    logic [7:0] exp_q[$];
    int failures, compares, cyc, n1, n2, bitc;
    integer seed;

    serial_rx_control serial_rx_control_i (.clk(clk), .rst_n(rst_n),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .rx_pin_in(rx_line), .rx_pin_out(rx_pin_out), .rx_pin_oe(rx_pin_oe),
        .ck_pin_in(ck_pin_in), .ck_pin_out(ck_pin_out),
        .ck_pin_oe(ck_pin_oe), .port_owned(port_owned), .rx_irq(rx_irq));
    remote_tx remote_tx_i (.clk(clk), .line(rx_line));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic cmp(input logic [7:0] got, input logic [7:0] e);
        compares++;
        if (got !== e) begin
            failures++;
            $display("ERROR at %0t: got %h expected %h", $time, got, e);
        end
    endtask

    task automatic tally_and_finish();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Read data is compared by the monitor one cycle after the strobe
    always @(posedge clk) begin
        if (rd_seen && exp_q.size() > 0)
            cmp(rdata, exp_q.pop_front());
        rd_seen <= rd;
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            failures++;
            tally_and_finish();
        end
    end

    // An idle cycle follows each strobe so no strobe is set twice at once
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e,
        input bit k);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        if (k)
            exp_q.push_back(e);
        rd <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wait_irq(input logic e, input int lim);
        int n;
        n = 0;
        while (rx_irq !== e && n < lim) begin
            @(posedge clk);
            n++;
        end
        cmp({7'h0, rx_irq}, {7'h0, e});
    endtask

    task automatic gap(output int n);
        logic p;
        p = ck_pin_out;
        n = 0;
        while (ck_pin_out === p && n < 2000) begin
            @(posedge clk);
            n++;
        end
    endtask

    initial begin
        seed = 32'h1e6e;
        rst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        ck_pin_in = 1'b1;
        rd_seen = 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd_reg(A_CTL, serial_rx_pkg::RCV_CTRL_RST, 1'b1);
        rd_reg(A_TX, serial_rx_pkg::XMT_CTRL_RST, 1'b1);
        rd_reg(A_DIV, serial_rx_pkg::DIVISOR_RST, 1'b1);
        rd_reg(A_DIR, serial_rx_pkg::PORTB_DIR_RST, 1'b1);
        rd_reg(8'h55, 8'h00, 1'b1);
        cmp({6'h0, rx_pin_oe, ck_pin_oe}, 8'h00);
        $display("done: reset values");
        for (int i = 0; i < 6; i++) begin
            ctl = $random(seed);
            dir = $random(seed);
            wr_reg(A_DIR, dir);
            wr_reg(A_CTL, {ctl[7], 7'h0});
            @(posedge clk);
            cmp({7'h0, port_owned}, {7'h0, ctl[7] & dir[1] & dir[2]});
        end
        wr_reg(A_DIR, 8'hff);
        wr_reg(A_CTL, 8'hdf);
        rd_reg(A_CTL, 8'hd8, 1'b1);
        $display("done: pin ownership");
        for (int i = 0; i < 3; i++) begin
            hs = (i != 0);
            x = (i == 0) ? 8'h01 : (i == 1 ? 8'h00 : 8'h03);
            wr_reg(A_TX, {5'h0, hs, 2'h0});
            wr_reg(A_DIV, x);
            wr_reg(A_CTL, 8'h90);
            bitc = (hs ? 16 : 64) * (x + 1);
            d = $random(seed);
            remote_tx_i.send(d, 1'b0, 1'b0, 1'b1, bitc, 1'b0);
            wait_irq(1'b1, 200);
            rd_reg(A_BUF, d, 1'b1);
            wait_irq(1'b0, 4);
        end
        $display("done: async rates");
        remote_tx_i.send(8'hc3, 1'b0, 1'b0, 1'b0, 64, 1'b0);
        wait_irq(1'b1, 200);
        rd_reg(A_BUF, 8'hc3, 1'b1);
        rd_reg(A_CTL, 8'h94, 1'b1);
        remote_tx_i.send(8'h5a, 1'b0, 1'b0, 1'b1, 64, 1'b1);
        wait_irq(1'b1, 200);
        rd_reg(A_BUF, 8'h5a, 1'b1);
        rd_reg(A_CTL, 8'h90, 1'b1);
        $display("done: framing and majority");
        for (int i = 0; i < 3; i++) begin
            d = $random(seed);
            remote_tx_i.send(d, 1'b0, 1'b0, 1'b1, 64, 1'b0);
        end
        rd_reg(A_CTL, 8'h92, 1'b1);
        wr_reg(A_CTL, 8'h80);
        rd_reg(A_CTL, 8'h80, 1'b1);
        for (int i = 0; i < 3; i++)
            rd_reg(A_BUF, 8'h00, 1'b0);
        wait_irq(1'b0, 4);
        $display("done: overrun");
        wr_reg(A_CTL, 8'hd8);
        remote_tx_i.send(8'h11, 1'b1, 1'b0, 1'b1, 64, 1'b0);
        cmp({7'h0, rx_irq}, 8'h00);
        remote_tx_i.send(8'h42, 1'b1, 1'b1, 1'b1, 64, 1'b0);
        wait_irq(1'b1, 200);
        rd_reg(A_BUF, 8'h42, 1'b1);
        rd_reg(A_CTL, 8'hd9, 1'b1);
        $display("done: address detect");
        wr_reg(A_CTL, 8'h00);
        wr_reg(A_TX, 8'h94);
        wr_reg(A_DIV, 8'h02);
        rd_reg(A_DIV, 8'h02, 1'b1);
        wr_reg(A_CTL, 8'ha0);
        gap(n1);
        gap(n1);
        gap(n2);
        cmp(8'(n1 + n2), 8'h0c);
        cmp({7'h0, ck_pin_oe}, 8'h01);
        wait_irq(1'b1, 300);
        rd_reg(A_BUF, 8'hff, 1'b1);
        rd_reg(A_CTL, 8'h80, 1'b1);
        $display("done: sync single receive");
        wr_reg(A_DIV, 8'hc8);
        wr_reg(A_CTL, 8'h90);
        gap(n1);
        repeat (20) @(posedge clk);
        // Old rate would need about 380 more cycles before its next edge
        wr_reg(A_DIV, 8'h01);
        gap(n2);
        cmp({7'h0, n2 <= 12}, 8'h01);
        wr_reg(A_CTL, 8'h00);
        $display("done: divisor restart");
        repeat (2) @(posedge clk);
        tally_and_finish();
    end
endmodule
